// file: tgc_timer.sv
/*
 * gated 16-bit timer/counter with two-bit prescaler, axi4-lite slave.
 * assumes resetn_in is the power-on/brown-out reset; other resets of the
 * chip never reach this block. pins arrive asynchronously.
 */
// Design decision made here: register access over AXI4-Lite.
`timescale 1ns/1ps
module tgc_timer (
  // clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // axi4-lite write
  input wire logic [tgc_pkg::ADDR_W-1:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  // axi4-lite read
  input wire logic [tgc_pkg::ADDR_W-1:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  // pins and configuration
  input wire logic ext_count_clock_in,
  input wire logic lp_osc_clock_in,
  input wire logic gate_in_n_in,
  input wire logic cfg_rc_no_clkout_in,
  input wire logic sleep_in,
  // status
  output logic lp_osc_run_out,
  output logic irq_out
);
  import tgc_pkg::*;

  // ==========================================================
  // registers
  logic [7:0] ctl_reg, int_ctrl_reg, aw_idx_reg, w_data_reg;
  logic flag_reg, irq_en_reg, pend_reg, lp_osc_reg, rd_ctl_reg;
  logic [15:0] count_reg;
  logic [1:0] div_reg, bresp_reg, rresp_reg;
  tgc_wr_state_t wr_state_reg;
  logic aw_have_reg, w_have_reg, w_lane_reg, bvalid_reg, rvalid_reg;
  logic [31:0] rdata_reg;
  // combinational
  logic [3:0] pin_level, pin_rise;
  logic cfg_q, gate_q, lp_active, ext_rise, instr_tick, src_tick;
  logic count_en, inc, wrap, wr_fire, wr_low, wr_high, rd_hit;
  logic [7:0] rd_idx, rd_value;
  function automatic logic is_mapped(input logic [7:0] idx);
    return idx == IDX_INT_CTRL || idx == IDX_PERIPH_FLAGS ||
      idx == IDX_COUNT_LOW || idx == IDX_COUNT_HIGH ||
      idx == IDX_TIMER_CTRL || idx == IDX_PERIPH_IRQ_EN;
  endfunction
  function automatic logic [7:0] idx_of(input logic [ADDR_W-1:0] addr);
    return addr[ADDR_W-1:2];
  endfunction

  // ==========================================================
  // pin synchronisers
  // two-flop sync
  tgc_sync #(.W(4)) u_sync (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .pin_in({cfg_rc_no_clkout_in, gate_in_n_in, lp_osc_clock_in,
      ext_count_clock_in}),
    .level_out(pin_level),
    .rise_out(pin_rise)
  );

  assign cfg_q = pin_level[3];
  assign gate_q = pin_level[2];

  // ==========================================================
  // clock source selection
  // oscillator gated by config
  assign lp_active = ctl_reg[CTL_LP_OSC] && cfg_q;
  // lp oscillator replaces the count pin when active
  assign ext_rise = lp_active ? pin_rise[1] : pin_rise[0];

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      lp_osc_reg <= 1'b0;
    end else begin
      lp_osc_reg <= lp_active;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      div_reg <= 2'h0;
    end else begin
      div_reg <= div_reg + 2'h1;
    end
  end
  // core clock is stopped during sleep, so no instruction cycles
  assign instr_tick = (div_reg == 2'(INSTR_DIV - 1)) && !sleep_in;
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      pend_reg <= 1'b0;
    end else begin
      // stale edges from other modes must not leak into synced counting
      pend_reg <= ctl_reg[CTL_CLK_SRC] && !ctl_reg[CTL_SYNC_N] &&
        (ext_rise || (pend_reg && !instr_tick));
    end
  end

  always_comb begin
    if (!ctl_reg[CTL_CLK_SRC]) begin
      src_tick = instr_tick;
    end else if (ctl_reg[CTL_SYNC_N]) begin
      src_tick = ext_rise;
    end else begin
      src_tick = pend_reg && instr_tick;
    end
  end

  assign count_en = ctl_reg[CTL_RUN] &&
    (!ctl_reg[CTL_GATE_EN] || !gate_q);

  tgc_prescaler u_presc (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .clear_in(wr_low || wr_high),
    .ratio_in(ctl_reg[CTL_PS_HI:CTL_PS_LO]),
    .tick_in(src_tick && count_en),
    .tick_out(inc)
  );

  // ==========================================================
  // count and overflow
  assign wrap = inc && count_reg == COUNT_MAX;

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      count_reg <= 16'h0000;
    end else if (wr_low) begin
      count_reg[7:0] <= w_data_reg;
    end else if (wr_high) begin
      count_reg[15:8] <= w_data_reg;
    end else if (inc) begin
      count_reg <= count_reg + 16'h1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      flag_reg <= 1'b0;
    end else if (wrap) begin
      flag_reg <= 1'b1;
    end else if (wr_fire && aw_idx_reg == IDX_PERIPH_FLAGS) begin
      flag_reg <= w_data_reg[FLG_OVERFLOW];
    end
  end

  assign irq_out = flag_reg && irq_en_reg &&
    int_ctrl_reg[INT_GLOBAL] && int_ctrl_reg[INT_PERIPH];
  assign lp_osc_run_out = lp_osc_reg;

  // ==========================================================
  // control registers
  assign wr_fire = aw_have_reg && w_have_reg &&
    wr_state_reg == TGC_WR_IDLE && w_lane_reg;
  assign wr_low = wr_fire && aw_idx_reg == IDX_COUNT_LOW;
  assign wr_high = wr_fire && aw_idx_reg == IDX_COUNT_HIGH;

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      ctl_reg <= CTL_RESET;
    end else if (wr_fire && aw_idx_reg == IDX_TIMER_CTRL) begin
      ctl_reg <= w_data_reg & CTL_MASK;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      int_ctrl_reg <= REG_RESET;
      irq_en_reg <= 1'b0;
    end else if (wr_fire) begin
      if (aw_idx_reg == IDX_INT_CTRL) begin
        int_ctrl_reg <= w_data_reg & INT_MASK;
      end
      if (aw_idx_reg == IDX_PERIPH_IRQ_EN) begin
        irq_en_reg <= w_data_reg[IEN_OVERFLOW];
      end
    end
  end

  // ==========================================================
  // axi4-lite write channel
  assign s_axi_awready_out = !aw_have_reg && wr_state_reg == TGC_WR_IDLE;
  assign s_axi_wready_out = !w_have_reg && wr_state_reg == TGC_WR_IDLE;

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      wr_state_reg <= TGC_WR_IDLE;
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
      aw_idx_reg <= 8'h00;
      w_data_reg <= 8'h00;
      w_lane_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid_in && s_axi_awready_out) begin
        aw_have_reg <= 1'b1;
        aw_idx_reg <= idx_of(s_axi_awaddr_in);
      end
      if (s_axi_wvalid_in && s_axi_wready_out) begin
        w_have_reg <= 1'b1;
        w_data_reg <= s_axi_wdata_in[7:0];
        w_lane_reg <= s_axi_wstrb_in[0];
      end
      unique case (wr_state_reg)
        TGC_WR_IDLE: begin
          if (aw_have_reg && w_have_reg) begin
            wr_state_reg <= TGC_WR_RESP;
            bvalid_reg <= 1'b1;
            bresp_reg <= is_mapped(aw_idx_reg) ? RESP_OKAY : RESP_SLVERR;
          end
        end
        TGC_WR_RESP: begin
          if (s_axi_bready_in) begin
            wr_state_reg <= TGC_WR_IDLE;
            bvalid_reg <= 1'b0;
            aw_have_reg <= 1'b0;
            w_have_reg <= 1'b0;
          end
        end
        default: begin
          wr_state_reg <= TGC_WR_IDLE;
        end
      endcase
    end
  end

  assign s_axi_bvalid_out = bvalid_reg;
  assign s_axi_bresp_out = bresp_reg;

  // ==========================================================
  // axi4-lite read channel
  assign s_axi_arready_out = !rvalid_reg;
  assign rd_idx = idx_of(s_axi_araddr_in);
  assign rd_hit = is_mapped(rd_idx);

  always_comb begin
    unique case (rd_idx)
      IDX_INT_CTRL: rd_value = int_ctrl_reg;
      IDX_PERIPH_FLAGS: rd_value = {7'h00, flag_reg};
      IDX_COUNT_LOW: rd_value = count_reg[7:0];
      IDX_COUNT_HIGH: rd_value = count_reg[15:8];
      IDX_TIMER_CTRL: rd_value = ctl_reg & CTL_MASK;
      IDX_PERIPH_IRQ_EN: rd_value = {7'h00, irq_en_reg};
      default: rd_value = 8'h00;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0;
      rresp_reg <= RESP_OKAY;
      rd_ctl_reg <= 1'b0;
    end else if (s_axi_arvalid_in && s_axi_arready_out) begin
      rvalid_reg <= 1'b1;
      rdata_reg <= {24'h0, rd_value};
      rresp_reg <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      rd_ctl_reg <= rd_idx == IDX_TIMER_CTRL;
    end else if (s_axi_rready_in) begin
      rvalid_reg <= 1'b0;
    end
  end

  assign s_axi_rvalid_out = rvalid_reg;
  assign s_axi_rdata_out = rdata_reg;
  assign s_axi_rresp_out = rresp_reg;

  // ==========================================================
  // checks
  default clocking @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  property p_freeze;
    !ctl_reg[CTL_RUN] && !wr_low && !wr_high |=> $stable(count_reg);
  endproperty
  a_freeze: assert property (p_freeze) else $error("count moved");
  property p_internal;
    !ctl_reg[CTL_CLK_SRC] && count_en && instr_tick && !wr_low &&
      !wr_high && ctl_reg[CTL_PS_HI:CTL_PS_LO] == 2'h0 |=>
      count_reg == $past(count_reg) + 16'h1;
  endproperty
  a_internal: assert property (p_internal) else $error("no tick");
  property p_async;
    ctl_reg[CTL_CLK_SRC] && ctl_reg[CTL_SYNC_N] && count_en && ext_rise &&
      !wr_low && !wr_high && ctl_reg[CTL_PS_HI:CTL_PS_LO] == 2'h0 |=>
      count_reg == $past(count_reg) + 16'h1;
  endproperty
  a_async: assert property (p_async) else $error("edge lost");
  property p_sync_wait;
    ctl_reg[CTL_CLK_SRC] && !ctl_reg[CTL_SYNC_N] && !instr_tick |->
      !src_tick;
  endproperty
  a_sync_wait: assert property (p_sync_wait) else $error("early");
  property p_gate;
    ctl_reg[CTL_GATE_EN] && gate_q && !wr_low && !wr_high |=>
      $stable(count_reg);
  endproperty
  a_gate: assert property (p_gate) else $error("gate open");
  property p_wrap;
    wrap && !wr_fire |=> flag_reg && count_reg == 16'h0000;
  endproperty
  a_wrap: assert property (p_wrap) else $error("bad wrap");
  property p_flag_hold;
    flag_reg && !(wr_fire && aw_idx_reg == IDX_PERIPH_FLAGS) |=> flag_reg;
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("flag lost");
  property p_por;
    disable iff (1'b0) !resetn_in |=> ctl_reg == 8'h00;
  endproperty
  a_por: assert property (p_por) else $error("ctl not cleared");
  property p_bit7;
    s_axi_rvalid_out && rd_ctl_reg |-> s_axi_rdata_out[7] == 1'b0;
  endproperty
  a_bit7: assert property (p_bit7) else $error("bit 7 set");
  property p_osc;
    ctl_reg[CTL_LP_OSC] && cfg_q |=> lp_osc_run_out;
  endproperty
  a_osc: assert property (p_osc) else $error("osc off");
endmodule

// file: tgc_pkg.sv
/*
 * shared constants for the gated 16-bit timer/counter: register indexes,
 * control field positions, reset values and bus response codes.
 * assumes a 32-bit axi4-lite bus, one aligned word per register.
 */
package tgc_pkg;

  // ==========================================================
  // register indexes (byte address is four times the index)
  localparam logic [7:0] IDX_INT_CTRL = 8'h0b;
  localparam logic [7:0] IDX_PERIPH_FLAGS = 8'h0c;
  localparam logic [7:0] IDX_COUNT_LOW = 8'h0e;
  localparam logic [7:0] IDX_COUNT_HIGH = 8'h0f;
  localparam logic [7:0] IDX_TIMER_CTRL = 8'h10;
  localparam logic [7:0] IDX_PERIPH_IRQ_EN = 8'h8c;
  localparam int ADDR_W = 10;

  // ==========================================================
  // timer_control fields
  localparam int CTL_RUN = 0;
  localparam int CTL_CLK_SRC = 1;
  localparam int CTL_SYNC_N = 2;
  localparam int CTL_LP_OSC = 3;
  localparam int CTL_PS_LO = 4;
  localparam int CTL_PS_HI = 5;
  localparam int CTL_GATE_EN = 6;
  localparam logic [7:0] CTL_MASK = 8'h7f;
  localparam logic [7:0] CTL_RESET = 8'h00;

  // ==========================================================
  // flag, enable and interrupt control fields
  localparam int FLG_OVERFLOW = 0;
  localparam int IEN_OVERFLOW = 0;
  localparam int INT_GLOBAL = 7;
  localparam int INT_PERIPH = 6;
  localparam logic [7:0] INT_MASK = 8'hc0;
  localparam logic [7:0] REG_RESET = 8'h00;

  // ==========================================================
  // timing and bus codes
  localparam int INSTR_DIV = 4;
  localparam logic [15:0] COUNT_MAX = 16'hffff;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    TGC_WR_IDLE = 2'h1,
    TGC_WR_RESP = 2'h2
  } tgc_wr_state_t;

endpackage

// file: tgc_sync.sv
/*
 * two-stage synchroniser with rising-edge detect, one bit per lane.
 * assumes inputs are asynchronous pins; only the second stage is used.
 */
`timescale 1ns/1ps
module tgc_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // pins
  input wire logic [W-1:0] pin_in,
  // synchronised view
  output logic [W-1:0] level_out,
  output logic [W-1:0] rise_out
);

  logic [W-1:0] meta_reg;
  logic [W-1:0] level_reg;
  logic [W-1:0] last_reg;

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      meta_reg <= '0;
      level_reg <= '0;
      last_reg <= '0;
    end else begin
      meta_reg <= pin_in;
      level_reg <= meta_reg;
      last_reg <= level_reg;
    end
  end

  assign level_out = level_reg;
  assign rise_out = level_reg & ~last_reg;

endmodule

// file: tgc_prescaler.sv
/*
 * two-bit prescaler: passes every 1st, 2nd, 4th or 8th tick.
 * assumes tick_in is a one-cycle enable on the system clock.
 */
`timescale 1ns/1ps
module tgc_prescaler (
  // clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // control
  input wire logic clear_in,
  input wire logic [1:0] ratio_in,
  // ticks
  input wire logic tick_in,
  output logic tick_out
);

  logic [2:0] cnt_reg;
  logic [2:0] mask;

  assign mask = 3'((4'h1 << ratio_in) - 4'h1);
  assign tick_out = tick_in && ((cnt_reg & mask) == mask);

  always_ff @(posedge clk_in) begin
    if (!resetn_in || clear_in) begin
      cnt_reg <= 3'h0;
    end else if (tick_in) begin
      cnt_reg <= cnt_reg + 3'h1;
    end
  end

  default clocking @(posedge clk_in); endclocking
  default disable iff (!resetn_in);

  property p_div8;
    tick_out && ratio_in == 2'h3 |-> cnt_reg == 3'h7;
  endproperty
  a_div8: assert property (p_div8) else $error("divide-by-8 slip");

endmodule

// file: tgc_pins_model.sv
/*
 * partner model: external count pin, low-power oscillator, gate pin.
 * assumes the bench calls its tasks just after a clock edge; each task
 * steps a few ns off that edge before it moves a pin.
 */
`timescale 1ns/1ps
module tgc_pins_model (
  // oscillator control
  input wire logic lp_run_in,
  // pins
  output logic ext_clk_out,
  output logic lp_clk_out,
  output logic gate_n_out
);
  initial begin
    ext_clk_out = 1'b0;
    lp_clk_out = 1'b0;
    gate_n_out = 1'b1;
  end
  // oscillator follows enable only
  // odd half period keeps it unrelated to the system clock
  always #97 lp_clk_out = lp_run_in ? ~lp_clk_out : 1'b0;
  // rising edges on the count pin
  task automatic ext_pulses(input int n, input int half_ns);
    #13;
    repeat (n) begin
      #(half_ns) ext_clk_out = 1'b1;
      #(half_ns) ext_clk_out = 1'b0;
    end
  endtask
  // gate level, low lets the count run
  task automatic set_gate(input logic v);
    #13 gate_n_out = v;
  endtask
endmodule

// file: gated_16bit_timer_counter_test.sv
/*
 * self-checking bench of the timer/counter over axi4-lite.
 * assumes tgc_pkg, tgc_timer and tgc_pins_model are compiled first.
 */
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin \
  bad_count++; $display("[FAIL] %0t got %0h exp %0h", $time, g, e); end end
module gated_16bit_timer_counter_test;
  import tgc_pkg::*;
  // ==========================================================
  // signals
  logic clk_in, resetn_in, awvalid, wvalid, arvalid;
  logic awready, wready, arready, bvalid, rvalid;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [31:0] wdata, rdata, v;
  logic [1:0] bresp, rresp;
  logic cfg_rc, sleep, lp_run, irq, ext_clk, lp_clk, gate_n;
  logic [15:0] cnt, c2;
  logic [7:0] mode [3] = '{8'h03, 8'h07, 8'h17};
  int bad_count, num_checks, cyc, t_wr, el, k, n;

  tgc_timer i_dut (.clk_in(clk_in), .resetn_in(resetn_in),
    .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid),
    .s_axi_awready_out(awready), .s_axi_wdata_in(wdata),
    .s_axi_wstrb_in(4'h1), .s_axi_wvalid_in(wvalid),
    .s_axi_wready_out(wready), .s_axi_bresp_out(bresp),
    .s_axi_bvalid_out(bvalid), .s_axi_bready_in(1'b1),
    .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
    .s_axi_arready_out(arready), .s_axi_rdata_out(rdata),
    .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
    .s_axi_rready_in(1'b1), .ext_count_clock_in(ext_clk),
    .lp_osc_clock_in(lp_clk), .gate_in_n_in(gate_n),
    .cfg_rc_no_clkout_in(cfg_rc), .sleep_in(sleep),
    .lp_osc_run_out(lp_run), .irq_out(irq));
  tgc_pins_model i_pins (.lp_run_in(lp_run), .ext_clk_out(ext_clk),
    .lp_clk_out(lp_clk), .gate_n_out(gate_n));

  initial begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end
  always @(posedge clk_in) cyc <= cyc + 1;

  // ==========================================================
  // closing and bus tasks
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic hang;
    bad_count++;
    $display("[FAIL] %0t wait timed out", $time);
    wrap_up();
  endtask
  task automatic idle(input int c);
    repeat (c) @(posedge clk_in);
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d,
                    input logic [1:0] er = RESP_OKAY);
    int i;
    awaddr <= {idx, 2'b00};
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    i = 0;
    // always pass one edge: the last answer may still show here
    do begin
      @(posedge clk_in);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      i++;
    end while (i < 40 && bvalid !== 1'b1);
    t_wr = cyc;
    if (bvalid !== 1'b1) hang();
    `CHK(bresp, er)
  endtask
  task automatic rd(input logic [7:0] idx, output logic [31:0] d,
                    input logic [1:0] er = RESP_OKAY);
    int i;
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    i = 0;
    do begin
      @(posedge clk_in);
      if (arvalid && arready) arvalid <= 1'b0;
      i++;
    end while (i < 40 && rvalid !== 1'b1);
    d = rdata;
    if (rvalid !== 1'b1) hang();
    `CHK(rresp, er)
  endtask
  task automatic set_cnt(input logic [15:0] c);
    wr(IDX_COUNT_LOW, c[7:0]);
    wr(IDX_COUNT_HIGH, c[15:8]);
  endtask
  task automatic rd_cnt(output logic [15:0] c);
    logic [31:0] a, b;
    rd(IDX_COUNT_LOW, a);
    rd(IDX_COUNT_HIGH, b);
    c = {b[7:0], a[7:0]};
  endtask
  // run for a while from a start value, leave delta in cnt
  task automatic timed(input logic [7:0] ctl, input int c,
                       input logic [15:0] start);
    int t0;
    set_cnt(start);
    wr(IDX_TIMER_CTRL, ctl);
    t0 = t_wr;
    idle(c);
    wr(IDX_TIMER_CTRL, 8'h00);
    el = t_wr - t0;
    rd_cnt(cnt);
    cnt = cnt - start;
  endtask
  function automatic int ticks(int c, int ps);
    return c / (INSTR_DIV << ps);
  endfunction
  // one tick of slack for prescaler phase
  function automatic logic near(logic [15:0] c, int e);
    return c >= e - 1 && c <= e + 1;
  endfunction

  // ==========================================================
  // main sequence
  initial begin
    resetn_in = 1'b0;
    {awvalid, wvalid, arvalid, cfg_rc, sleep} = '0;
    {awaddr, araddr, wdata} = '0;
    v = $urandom(32'haa05);
    idle(2);
    resetn_in <= 1'b1;
    idle(1);
    rd(IDX_TIMER_CTRL, v);
    `CHK(v, 32'h0)
    `CHK(lp_run, 1'b0)
    wr(IDX_TIMER_CTRL, 8'hfe);
    rd(IDX_TIMER_CTRL, v);
    `CHK(v, 32'h7e)
    wr(IDX_INT_CTRL, 8'hff);
    rd(IDX_INT_CTRL, v);
    `CHK(v, 32'hc0)
    wr(IDX_PERIPH_IRQ_EN, 8'hff);
    rd(IDX_PERIPH_IRQ_EN, v);
    `CHK(v, 32'h1)
    wr(IDX_TIMER_CTRL, 8'h00);
    wr(IDX_INT_CTRL, 8'h00);
    wr(IDX_PERIPH_IRQ_EN, 8'h00);
    wr(8'h01, 8'h5a, RESP_SLVERR);
    rd(8'h01, v, RESP_SLVERR);
    `CHK(v, 32'h0)
    for (k = 0; k < 4; k++) begin
      cnt = 16'($urandom);
      set_cnt(cnt);
      rd_cnt(c2);
      `CHK(c2, cnt)
    end
    $display("register test done");
    for (k = 0; k < 4; k++) begin
      timed({2'b00, 2'(k), 1'b0, 1'($urandom), 2'b01},
            200 + $urandom % 100, 16'($urandom));
      `CHK(near(cnt, ticks(el, k)), 1'b1)
      rd_cnt(cnt);
      idle(40);
      rd_cnt(c2);
      `CHK(c2, cnt)
    end
    $display("prescale test done");
    i_pins.set_gate(1'b1);
    timed(8'h41, 200, 16'h0);
    `CHK(cnt, 16'h0)
    timed(8'h01, 200, 16'h0);
    `CHK(near(cnt, ticks(el, 0)), 1'b1)
    i_pins.set_gate(1'b0);
    timed(8'h41, 200, 16'h0);
    `CHK(near(cnt, ticks(el, 0)), 1'b1)
    timed(8'h40, 200, 16'h0);
    `CHK(cnt, 16'h0)
    $display("gate test done");
    for (k = 0; k < 3; k++) begin
      n = 4 + $urandom % 12;
      set_cnt(16'h0);
      wr(IDX_TIMER_CTRL, mode[k]);
      i_pins.ext_pulses(n, 250);
      idle(20);
      wr(IDX_TIMER_CTRL, 8'h00);
      rd_cnt(cnt);
      `CHK(cnt, 16'(n >> (k / 2)))
    end
    wr(IDX_TIMER_CTRL, 8'h02);
    i_pins.ext_pulses(6, 250);
    idle(20);
    rd_cnt(c2);
    `CHK(c2, cnt)
    $display("external test done");
    // clear flag, then preload count to 16'hfffd before enabling
    wr(IDX_PERIPH_FLAGS, 8'h00);
    timed(8'h01, 60, 16'hfffd);
    `CHK(near(cnt, ticks(el, 0)), 1'b1)
    rd(IDX_PERIPH_FLAGS, v);
    `CHK(v, 32'h1)
    `CHK(irq, 1'b0)
    wr(IDX_PERIPH_IRQ_EN, 8'h01);
    wr(IDX_INT_CTRL, 8'h80);
    `CHK(irq, 1'b0)
    wr(IDX_INT_CTRL, 8'hc0);
    `CHK(irq, 1'b1)
    idle(50);
    rd(IDX_PERIPH_FLAGS, v);
    `CHK(v, 32'h1)
    wr(IDX_PERIPH_FLAGS, 8'h00);
    `CHK(irq, 1'b0)
    wr(IDX_INT_CTRL, 8'h00);
    $display("overflow test done");
    cfg_rc <= 1'b1;
    wr(IDX_TIMER_CTRL, 8'h0a);
    idle(4);
    `CHK(lp_run, 1'b1)
    sleep <= 1'b1;
    // oscillator settles before the run bit
    idle(20);
    `CHK(lp_run, 1'b1)
    timed(8'h0f, 300, 16'h0);
    `CHK(cnt != 16'h0, 1'b1)
    timed(8'h01, 200, 16'h0);
    `CHK(cnt, 16'h0)
    sleep <= 1'b0;
    idle(20);
    cfg_rc <= 1'b0;
    timed(8'h0f, 300, 16'h0);
    `CHK(cnt, 16'h0)
    `CHK(lp_run, 1'b0)
    $display("oscillator test done");
    wrap_up();
  end
endmodule
